// *** u_line_overhead_control.sv ***
// u-line control register 0 with apb access and superframe-aligned overhead bits
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "u_line_ctrl_regs.svh"


module u_line_overhead_control (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ULC_ADDR_W-1:0] paddr,
    input wire logic [`ULC_DATA_W-1:0] pwdata,
    output logic [`ULC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // device side inputs
    input wire logic termination_side_select,
    input wire logic st_info1_present,
    input wire logic st_info3_present,
    input wire logic superframe_boundary,
    input wire logic startup_attempt_done,
    // overhead bits toward the u transceiver
    output logic nt_test_overhead_bit,
    output logic power_status_a,
    output logic power_status_b,
    output logic st_activity_indicator,
    output logic activation_overhead_bit,
    // control levels toward the u block
    output logic deactivate_request,
    output logic u_only_activation,
    output logic force_upstream_transparency,
    output logic initiate_startup
);

    // software-visible control register
    logic [`ULC_REG_W-1:0] u_line_control_0_ff;
    // apb answer state and registered answer
    u_line_ctrl_pkg::apb_state_t apb_state_ff;
    u_line_ctrl_pkg::apb_state_t nxt_apb_state;
    logic [`ULC_DATA_W-1:0] prdata_ff;
    logic [`ULC_DATA_W-1:0] nxt_prdata;
    logic pslverr_ff;
    logic nxt_pslverr;
    // start-up tracking
    u_line_ctrl_pkg::startup_state_t su_state_ff;
    // sampled lt/nt mode
    logic lt_mode_ff;
    // registered control outputs
    logic deactivate_ff;
    logic uoa_ff;
    logic force_upstream_transparency_ff;
    // overhead group: next value and the applied value
    u_line_ctrl_pkg::overhead_bits_t nxt_ovh;
    u_line_ctrl_pkg::overhead_bits_t ovh_applied;
    // decoded bus events
    logic access;
    logic wr_commit;
    logic hit_control;
    logic hit_status;
    logic wr_start;
    logic [`ULC_REG_W-1:0] status_word;

    // access phase of any transfer
    assign access = psel && penable;
    // a write takes effect only at the edge where pready is seen high
    assign wr_commit = access && pwrite && (apb_state_ff == u_line_ctrl_pkg::apb_answer);
    // address decode
    assign hit_control = (paddr == `ULC_CONTROL_0_ADDR);
    assign hit_status = (paddr == `ULC_STATUS_ADDR);
    // software writing one to the start-up bit
    assign wr_start = wr_commit && hit_control && pwdata[`ULC_STARTUP_BIT];

    // status word: applied overhead bits, attempt pending, mode
    always_comb
    begin
        status_word = '0;
        status_word[`ULC_ST_OVH_MSB:`ULC_ST_OVH_LSB] = ovh_applied;
        status_word[`ULC_ST_BUSY_BIT] = (su_state_ff == u_line_ctrl_pkg::su_running);
        status_word[`ULC_ST_LT_BIT] = lt_mode_ff;
    end

    // apb next state, read data and error
    always_comb
    begin
        nxt_apb_state = apb_state_ff;
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        case (apb_state_ff)
            u_line_ctrl_pkg::apb_idle:
            begin
                // first access cycle: capture answer, raise pready next
                if (access)
                begin
                    nxt_apb_state = u_line_ctrl_pkg::apb_answer;
                    nxt_pslverr = 1'b0;
                    nxt_prdata = '0;
                    if (hit_control)
                    begin
                        nxt_prdata = {24'h000000, u_line_control_0_ff};
                    end
                    else if (hit_status)
                    begin
                        // status is read only: a write errors
                        nxt_prdata = {24'h000000, status_word};
                        nxt_pslverr = pwrite;
                    end
                    else
                    begin
                        // unmapped address answers zero with an error
                        nxt_pslverr = 1'b1;
                    end
                end
            end
            u_line_ctrl_pkg::apb_answer:
            begin
                // transfer completes at this edge; drop pready
                nxt_apb_state = u_line_ctrl_pkg::apb_idle;
                nxt_pslverr = 1'b0;
            end
            default:
            begin
                nxt_apb_state = u_line_ctrl_pkg::apb_idle;
            end
        endcase
    end

    // apb answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            apb_state_ff <= u_line_ctrl_pkg::apb_idle;
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            apb_state_ff <= nxt_apb_state;
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // control register: upper bits plain storage, bit 0 self-clearing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            u_line_control_0_ff <= `ULC_CONTROL_0_RESET;
        end
        else
        begin
            // bits 7..1 take the written value
            if (wr_commit && hit_control)
            begin
                u_line_control_0_ff[`ULC_REG_W-1:1] <= pwdata[`ULC_REG_W-1:1];
            end
            // writing one starts; a new start beats the end of the old attempt
            if (wr_start)
            begin
                u_line_control_0_ff[`ULC_STARTUP_BIT] <= 1'b1;
            end
            else if (startup_attempt_done)
            begin
                u_line_control_0_ff[`ULC_STARTUP_BIT] <= 1'b0;
            end
        end
    end

    // start-up tracker mirrors bit 0 as a state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            su_state_ff <= u_line_ctrl_pkg::su_idle;
        end
        else
        begin
            case (su_state_ff)
                u_line_ctrl_pkg::su_idle:
                begin
                    // writing zero leaves it idle
                    if (wr_start)
                    begin
                        su_state_ff <= u_line_ctrl_pkg::su_running;
                    end
                end
                u_line_ctrl_pkg::su_running:
                begin
                    // end of attempt, unless restarted in the same cycle
                    if (startup_attempt_done && !wr_start)
                    begin
                        su_state_ff <= u_line_ctrl_pkg::su_idle;
                    end
                end
                default:
                begin
                    su_state_ff <= u_line_ctrl_pkg::su_idle;
                end
            endcase
        end
    end

    // mode sample from the device operation control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lt_mode_ff <= 1'b0;
        end
        else
        begin
            lt_mode_ff <= termination_side_select;
        end
    end

    // control levels toward the u block, registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            deactivate_ff <= 1'b0;
            uoa_ff <= 1'b0;
            force_upstream_transparency_ff <= 1'b0;
        end
        else
        begin
            // bit 6 means deactivate only in lt mode
            deactivate_ff <= lt_mode_ff && u_line_control_0_ff[`ULC_DEACT_BIT];
            // bit 4 lets the remote nt activate s/t in lt mode
            uoa_ff <= lt_mode_ff && u_line_control_0_ff[`ULC_UOA_BIT];
            // transparency in either mode
            force_upstream_transparency_ff <= u_line_control_0_ff[`ULC_FORCE_UPSTREAM_TRANSPARENCY_BIT];
        end
    end

    // next overhead group from register and s/t state
    always_comb
    begin
        nxt_ovh.nt_test = u_line_control_0_ff[`ULC_NT_TEST_BIT];
        if (lt_mode_ff)
        begin
            // lt: power status fields are reused, send all-normal
            nxt_ovh.ps_a = 1'b1;
            nxt_ovh.ps_b = 1'b1;
            nxt_ovh.st_activity = 1'b0;
            // downstream act zero unless forced
            if (u_line_control_0_ff[`ULC_FORCE_ACT_BIT])
            begin
                nxt_ovh.activation = u_line_control_0_ff[`ULC_ACT_VALUE_BIT];
            end
            else
            begin
                nxt_ovh.activation = 1'b0;
            end
        end
        else
        begin
            // nt: power status straight from bits 6 and 5
            nxt_ovh.ps_a = u_line_control_0_ff[`ULC_PS_A_BIT];
            nxt_ovh.ps_b = u_line_control_0_ff[`ULC_PS_B_BIT];
            // activity on s/t, or forced high
            nxt_ovh.st_activity = u_line_control_0_ff[`ULC_SAI_BIT] || st_info1_present
                || st_info3_present;
            // act tracks info3 unless forced
            if (u_line_control_0_ff[`ULC_FORCE_ACT_BIT])
            begin
                nxt_ovh.activation = u_line_control_0_ff[`ULC_ACT_VALUE_BIT];
            end
            else
            begin
                nxt_ovh.activation = st_info3_present;
            end
        end
    end

    // overhead group only changes at a superframe boundary
    superframe_latch #(
        .W(`ULC_OVH_W),
        .RESET_VAL(`ULC_OVH_RESET)
    ) u_ovh_latch (
        .pclk(pclk),
        .presetn(presetn),
        .load(superframe_boundary),
        .d(nxt_ovh),
        .q(ovh_applied)
    );

    // outputs
    assign prdata = prdata_ff;
    assign pready = (apb_state_ff == u_line_ctrl_pkg::apb_answer);
    assign pslverr = pslverr_ff;
    assign nt_test_overhead_bit = ovh_applied.nt_test;
    assign power_status_a = ovh_applied.ps_a;
    assign power_status_b = ovh_applied.ps_b;
    assign st_activity_indicator = ovh_applied.st_activity;
    assign activation_overhead_bit = ovh_applied.activation;
    assign deactivate_request = deactivate_ff;
    assign u_only_activation = uoa_ff;
    assign force_upstream_transparency = force_upstream_transparency_ff;
    assign initiate_startup = u_line_control_0_ff[`ULC_STARTUP_BIT];

endmodule : u_line_overhead_control

`default_nettype wire

// *** u_line_ctrl_regs.svh ***
// offsets, field positions, reset values and widths of the u-line control block
`ifndef U_LINE_CTRL_REGS_SVH
`define U_LINE_CTRL_REGS_SVH

// apb address width and data width
`define ULC_ADDR_W 12
`define ULC_DATA_W 32

// register indices as printed, and their byte addresses (index times four)
`define ULC_CONTROL_0_INDEX 8'h07
`define ULC_CONTROL_0_ADDR 12'h01c
`define ULC_STATUS_INDEX 8'h08
`define ULC_STATUS_ADDR 12'h020

// control register width and reset value
`define ULC_REG_W 8
`define ULC_CONTROL_0_RESET 8'he0

// control register field positions
`define ULC_NT_TEST_BIT 7
`define ULC_PS_A_BIT 6
`define ULC_DEACT_BIT 6
`define ULC_PS_B_BIT 5
`define ULC_SAI_BIT 4
`define ULC_UOA_BIT 4
`define ULC_FORCE_UPSTREAM_TRANSPARENCY_BIT 3
`define ULC_FORCE_ACT_BIT 2
`define ULC_ACT_VALUE_BIT 1
`define ULC_STARTUP_BIT 0

// status register field positions
`define ULC_ST_OVH_LSB 0
`define ULC_ST_OVH_MSB 4
`define ULC_ST_BUSY_BIT 5
`define ULC_ST_LT_BIT 6

// overhead bit group: width and reset value {nt, ps_a, ps_b, sai, act}
`define ULC_OVH_W 5
`define ULC_OVH_RESET 5'h1c

`endif

// *** u_line_ctrl_pkg.sv ***
// types shared by the u-line overhead control block
`default_nettype none

package u_line_ctrl_pkg;

    // overhead bits sent on the u-interface, applied as one group per superframe
    typedef struct packed {
        logic nt_test;      // nt test mode bit, 0 = test
        logic ps_a;         // power status a
        logic ps_b;         // power status b
        logic st_activity;  // s/t activity indicator
        logic activation;   // act bit, upstream in nt, downstream in lt
    } overhead_bits_t;

    // apb answer phase
    typedef enum logic [0:0] {
        apb_idle   = 1'b0,  // waiting for an access phase
        apb_answer = 1'b1   // pready raised, transfer completes next edge
    } apb_state_t;

    // start-up attempt tracking
    typedef enum logic [0:0] {
        su_idle    = 1'b0,  // no attempt pending
        su_running = 1'b1   // attempt requested, waiting for its end
    } startup_state_t;

endpackage : u_line_ctrl_pkg

`default_nettype wire

// *** superframe_latch.sv ***
// holding register that loads a new value only on a superframe boundary
`timescale 1ns/10ps
`default_nettype none

module superframe_latch #(
    parameter int W = 5,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // held value, replaced only at the boundary so a frame never mixes old and new
    logic [W-1:0] hold_ff;

    // load on the boundary pulse, otherwise keep
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold_ff <= RESET_VAL;
        end
        else if (load)
        begin
            hold_ff <= d;
        end
    end

    assign q = hold_ff;

endmodule : superframe_latch

`default_nettype wire

// *** u_link_partner.sv ***
// far-side model: superframe timing and start-up attempt end
`timescale 1ns/10ps
`default_nettype none

module u_link_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic initiate_startup,
    input wire logic slow,
    output logic superframe_boundary,
    output logic startup_attempt_done
);
    logic [3:0] sf_ff; // superframe cycle count
    logic [4:0] su_ff; // attempt length count
    // one boundary pulse every sixteen cycles
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            sf_ff <= 4'h0;
        else
            sf_ff <= sf_ff + 4'h1;
    assign superframe_boundary = (sf_ff == 4'hf);
    // attempt ends after a short or long run
    assign startup_attempt_done = initiate_startup && (su_ff == (slow ? 5'h14 : 5'h02));
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            su_ff <= 5'h00;
        else if (!initiate_startup || startup_attempt_done)
            su_ff <= 5'h00;
        else
            su_ff <= su_ff + 5'h01;
endmodule : u_link_partner
`default_nettype wire

// *** u_line_overhead_control_sva.sv ***
// assertions for the u-line overhead control block
`timescale 1ns/10ps
`default_nettype none
`include "u_line_ctrl_regs.svh"

module u_line_overhead_control_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ULC_ADDR_W-1:0] paddr,
    input wire logic [`ULC_DATA_W-1:0] pwdata,
    input wire logic pready,
    input wire logic termination_side_select,
    input wire logic st_info1_present,
    input wire logic st_info3_present,
    input wire logic superframe_boundary,
    input wire logic nt_test_overhead_bit,
    input wire logic power_status_a,
    input wire logic power_status_b,
    input wire logic st_activity_indicator,
    input wire logic activation_overhead_bit,
    input wire logic deactivate_request,
    input wire logic u_only_activation,
    input wire logic initiate_startup
);
    logic [7:0] sh_ff; // shadow of committed writes
    logic tq_ff; // mode pin one edge back
    logic tqq_ff; // mode pin two edges back
    logic wr_ctl, sf_nt, sf_lt, sai_exp, act_nt;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr_ctl = psel && penable && pready && pwrite && (paddr == `ULC_CONTROL_0_ADDR);
    assign sf_nt = superframe_boundary && !termination_side_select && !tq_ff;
    assign sf_lt = superframe_boundary && termination_side_select && tq_ff;
    assign sai_exp = st_info1_present || st_info3_present || sh_ff[4];
    assign act_nt = sh_ff[2] ? sh_ff[1] : st_info3_present;
    // shadow register and mode history
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            sh_ff <= `ULC_CONTROL_0_RESET;
            tq_ff <= 1'b0;
            tqq_ff <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
                sh_ff <= pwdata[7:0];
            tq_ff <= termination_side_select;
            tqq_ff <= tq_ff;
        end
    property p_nt_test;
        superframe_boundary |=> nt_test_overhead_bit == $past(sh_ff[7]);
    endproperty
    a_nt_test: assert property (p_nt_test) else $error("nt test bit wrong");
    property p_power;
        sf_nt |=> {power_status_a, power_status_b} == $past(sh_ff[6:5]);
    endproperty
    a_power: assert property (p_power) else $error("power status wrong");
    property p_sai;
        sf_nt |=> st_activity_indicator == $past(sai_exp);
    endproperty
    a_sai: assert property (p_sai) else $error("activity bit wrong");
    property p_act_nt;
        sf_nt |=> activation_overhead_bit == $past(act_nt);
    endproperty
    a_act_nt: assert property (p_act_nt) else $error("upstream act wrong");
    property p_lt;
        sf_lt |=> ##0 {power_status_a, power_status_b, st_activity_indicator} == 3'h6
            && activation_overhead_bit == $past(sh_ff[2] && sh_ff[1]);
    endproperty
    a_lt: assert property (p_lt) else $error("lt overhead wrong");
    property p_ctrl;
        termination_side_select == tq_ff && tq_ff == tqq_ff |->
            {deactivate_request, u_only_activation}
            == ({$past(sh_ff[6]), $past(sh_ff[4])} & {2{termination_side_select}});
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("lt control level wrong");
    property p_su_set;
        wr_ctl && pwdata[0] |=> initiate_startup;
    endproperty
    a_su_set: assert property (p_su_set) else $error("start-up not set");
    property p_hold;
        !superframe_boundary |=> $stable({nt_test_overhead_bit, power_status_a,
            power_status_b, st_activity_indicator, activation_overhead_bit});
    endproperty
    a_hold: assert property (p_hold) else $error("overhead changed mid frame");
endmodule : u_line_overhead_control_sva

bind u_line_overhead_control u_line_overhead_control_sva u_sva (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .termination_side_select, .st_info1_present, .st_info3_present, .superframe_boundary,
    .nt_test_overhead_bit, .power_status_a, .power_status_b, .st_activity_indicator,
    .activation_overhead_bit, .deactivate_request, .u_only_activation, .initiate_startup
);
`default_nettype wire

// *** u_line_overhead_control_tb_top.sv ***
// testbench for the u-line overhead control block
`timescale 1ns/10ps
`default_nettype none
`include "u_line_ctrl_regs.svh"

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module u_line_overhead_control_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic [`ULC_ADDR_W-1:0] paddr;
    logic [`ULC_DATA_W-1:0] pwdata, prdata;
    logic termination_side_select, st_info1_present, st_info3_present;
    logic superframe_boundary, startup_attempt_done, initiate_startup;
    logic nt_test_overhead_bit, power_status_a, power_status_b, st_activity_indicator;
    logic activation_overhead_bit, deactivate_request, u_only_activation;
    logic force_upstream_transparency;
    int checks, mismatches;
    wire [4:0] ovh = {nt_test_overhead_bit, power_status_a, power_status_b,
        st_activity_indicator, activation_overhead_bit};
    wire [2:0] ctl = {deactivate_request, u_only_activation, force_upstream_transparency};

    u_line_overhead_control u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .termination_side_select, .st_info1_present, .st_info3_present,
        .superframe_boundary, .startup_attempt_done, .nt_test_overhead_bit,
        .power_status_a, .power_status_b, .st_activity_indicator, .activation_overhead_bit,
        .deactivate_request, .u_only_activation, .force_upstream_transparency,
        .initiate_startup
    );
    u_link_partner u_far (
        .pclk, .presetn, .initiate_startup, .slow, .superframe_boundary, .startup_attempt_done
    );

    // 10 mhz clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // counts and verdict
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // a wait ran out
    task automatic to_fail;
        mismatches++;
        end_of_test();
    endtask : to_fail

    // one apb transfer, pready awaited with a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            to_fail();
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // wait for a boundary (0) or for the attempt to end (1)
    task automatic wait_for(input bit sel);
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while ((sel ? initiate_startup !== 1'b0 : superframe_boundary !== 1'b1) && n < 60);
        if (n >= 60)
            to_fail();
    endtask : wait_for

    // main sequence
    initial
    begin
        logic [31:0] q;
        logic e, lt, a1, a3;
        logic [7:0] v;
        logic [4:0] ex;
        checks = 0;
        mismatches = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = '0;
        pwdata = '0;
        {termination_side_select, st_info1_present, st_info3_present} = 3'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ULC_CONTROL_0_ADDR, 32'h0, q, e);
        `CHK(q, 32'he0)
        `CHK(ovh, 5'h1c)
        // unmapped read, status write
        apb(1'b0, 12'h040, 32'h0, q, e);
        `CHK({e, q}, 33'h100000000)
        apb(1'b1, `ULC_STATUS_ADDR, 32'hff, q, e);
        `CHK(e, 1'b1)
        // field, mode and s/t activity sweep
        ex = 5'h1c;
        for (int i = 0; i < 32; i++)
        begin
            v = {i[3:0], i[3:1] ^ i[2:0], 1'b0};
            lt = i[4];
            a1 = i[1];
            a3 = i[2] ^ i[3];
            wait_for(1'b0);
            termination_side_select <= lt;
            st_info1_present <= a1;
            st_info3_present <= a3;
            apb(1'b1, `ULC_CONTROL_0_ADDR, {24'h0, v}, q, e);
            @(posedge pclk);
            #1;
            `CHK(ovh, ex)
            if (lt)
                ex = {v[7], 3'h6, v[2] & v[1]};
            else
                ex = {v[7:5], v[4] | a1 | a3, v[2] ? v[1] : a3};
            wait_for(1'b0);
            #1;
            `CHK(ovh, ex)
            `CHK(ctl, {lt & v[6], lt & v[4], v[3]})
            apb(1'b0, `ULC_STATUS_ADDR, 32'h0, q, e);
            `CHK(q, {25'h0, lt, 1'b0, ex})
        end
        // start-up attempts, prompt then slow far side
        for (int s = 0; s < 2; s++)
        begin
            slow <= s[0];
            apb(1'b1, `ULC_CONTROL_0_ADDR, 32'h01, q, e);
            @(posedge pclk);
            #1;
            `CHK(initiate_startup, 1'b1)
            if (s == 1)
            begin
                // writing zero mid-attempt leaves the bit and the pending flag set
                apb(1'b1, `ULC_CONTROL_0_ADDR, 32'h00, q, e);
                #1;
                `CHK(initiate_startup, 1'b1)
                apb(1'b0, `ULC_STATUS_ADDR, 32'h0, q, e);
                `CHK(q[6:5], 2'h3)
            end
            wait_for(1'b1);
            apb(1'b0, `ULC_CONTROL_0_ADDR, 32'h0, q, e);
            `CHK(q, 32'h0)
        end
        end_of_test();
    end
endmodule : u_line_overhead_control_tb_top
`default_nettype wire
